//--- hdl/coprocessor_handshake_port.sv
// core-side coprocessor port: issue, handshake sampling, busy-wait, cancel
// assumes the core pipeline drives the issue inputs and accepts results
// as single-cycle pulses; coprocessors sit on the handshake pins
module coprocessor_handshake_port
   import coproc_port_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic issueValid,
   output logic issueReady,
   input wire logic [DATA_W-1:0] issueInstr,
   input wire kind_t issueKind,
   input wire logic condPass,
   input wire logic srcReady,
   input wire logic [DATA_W-1:0] srcData0,
   input wire logic [DATA_W-1:0] srcData1,
   input wire logic priorAbort,
   input wire logic irqPending,
   input wire logic privileged,
   output logic instrDone,
   output logic undefTrap,
   output logic destWrite,
   output logic destDouble,
   output logic [DATA_W-1:0] dest0,
   output logic [DATA_W-1:0] dest1,
   output logic fetchRequestN,
   output logic [DATA_W-1:0] fetchedInstructionBus,
   input wire logic [1:0] decodeHandshake,
   input wire logic [1:0] executeHandshake,
   output logic goAhead,
   output logic lateCancelOut,
   output logic privilegeIndicatorN,
   output logic [DATA_W-1:0] writeData,
   input wire logic [DATA_W-1:0] readData,
   output logic [DATA_W-1:0] instructionAddressBus,
   output logic [DATA_W-1:0] dataAddressBus
);

   typedef struct packed {
      mst_t st;
      kind_t kind;
      logic [DATA_W-1:0] fetched_instruction_bus;
      logic [DATA_W-1:0] s0;
      logic [DATA_W-1:0] s1;
      logic [DATA_W-1:0] addr;
      logic late;
      logic trap;
      logic done;
      logic privN;
   } mstate_t;

   localparam mstate_t M_RESET = '{S_IDLE, K_DATAOP, ZERO_WORD, ZERO_WORD,
      ZERO_WORD, ZERO_WORD, 1'b0, 1'b0, 1'b0, 1'b1};

   mstate_t m_reg;
   mstate_t m_next;
   xfer_if xf ();

   logic takeIssue;
   logic decAdvance;
   logic inExec;
   logic abandon;
   logic commit;
   hs_t hs;

   // a move out needs its register; other kinds never interlock
   assign decAdvance = srcReady || !toCoproc(m_reg.kind); // RULE8
   assign takeIssue = (m_reg.st == S_IDLE) && issueValid && !xf.busy;
   assign issueReady = (m_reg.st == S_IDLE) && !xf.busy;
   assign inExec = (m_reg.st == S_EXE) || (m_reg.st == S_BUSY);

   // fetch strobe low on entry to decode and again on issue
   assign fetchRequestN = !(takeIssue || ((m_reg.st == S_DEC) && decAdvance)); // RULE1 RULE8

   // decode bus counts only in the first execute cycle
   assign hs = (m_reg.st == S_EXE) ? hs_t'(decodeHandshake) : hs_t'(executeHandshake); // RULE11 RULE3

   // an interrupt or late cancel ends a busy-wait
   assign abandon = (m_reg.st == S_BUSY) && (irqPending || m_reg.late);

   // go-ahead: condition passed and still wanted
   assign goAhead = ((m_reg.st == S_EXE) && condPass) || ((m_reg.st == S_BUSY) && !abandon); // RULE2

   // LAST with go-ahead commits the instruction
   assign commit = inExec && goAhead && (hs == HS_LAST); // RULE3

   assign xf.start = commit && isTransfer(m_reg.kind);
   assign xf.kind = m_reg.kind;
   assign xf.src0 = m_reg.s0;
   assign xf.src1 = m_reg.s1;
   assign xf.cancel = m_reg.late; // RULE10

   // sequencer next state
   always_comb begin
      m_next = m_reg;
      m_next.late = 1'b0;
      m_next.trap = 1'b0;
      m_next.done = 1'b0;
      m_next.privN = !privileged;
      case (m_reg.st)
         S_IDLE: begin
            if (takeIssue) begin
               m_next.kind = issueKind;
               m_next.fetched_instruction_bus = issueInstr; // RULE1
               m_next.st = S_DEC;
            end
         end
         S_DEC: begin
            // data not ready: hold decode, strobe stays high
            if (decAdvance) begin
               m_next.s0 = srcData0;
               m_next.s1 = srcData1;
               m_next.addr = (m_reg.kind == K_SYSOUT) ? srcData0 : ZERO_WORD; // RULE14
               m_next.st = S_EXE;
            end
         end
         S_EXE, S_BUSY: begin
            if (m_reg.st == S_EXE) begin
               m_next.late = priorAbort; // RULE10
            end
            if (!goAhead) begin
               // failed condition or abandoned: handshake ignored
               m_next.st = S_IDLE; // RULE2
               m_next.done = 1'b1;
            end else begin
               case (hs)
                  HS_ABSENT: begin
                     m_next.trap = 1'b1; // RULE19
                     m_next.done = 1'b1;
                     m_next.st = S_IDLE;
                  end
                  HS_LAST: begin
                     m_next.done = 1'b1;
                     m_next.st = S_IDLE;
                  end
                  default: m_next.st = S_BUSY; // WAIT or GO
               endcase
            end
            if (m_next.st == S_IDLE) begin
               m_next.addr = ZERO_WORD;
            end
         end
         default: m_next = M_RESET;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         m_reg <= M_RESET;
      end else begin
         m_reg <= m_next;
      end
   end

   // data and status outputs straight from flops
   assign fetchedInstructionBus = m_reg.fetched_instruction_bus;
   assign instructionAddressBus = m_reg.addr; // RULE14
   assign dataAddressBus = m_reg.addr; // RULE14
   assign lateCancelOut = m_reg.late;
   assign undefTrap = m_reg.trap;
   assign instrDone = m_reg.done;
   assign privilegeIndicatorN = m_reg.privN;

   // post-commit data stages live in their own unit
   xfer_unit u_xfer (
      .clk(clk),
      .rstn(rstn),
      .xf(xf),
      .readData(readData),
      .writeData(writeData),
      .destWrite(destWrite),
      .destDouble(destDouble),
      .dest0(dest0),
      .dest1(dest1)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   fetch_decode_a: assert property (takeIssue |-> !fetchRequestN ##1
      (fetchedInstructionBus == $past(issueInstr) && m_reg.st == S_DEC)) // RULE1
      else $error("issued word not presented to decode");
   cond_fail_a: assert property (m_reg.st == S_EXE && !condPass |-> !goAhead ##1
      (m_reg.st == S_IDLE && !undefTrap)) // RULE2
      else $error("failed condition not ignored");
   last_commit_a: assert property (m_reg.st == S_BUSY && goAhead && hs_t'(executeHandshake) == HS_LAST
      && isTransfer(m_reg.kind) |=> xf.busy) // RULE3
      else $error("LAST did not commit transfer");
   interlock_a: assert property (m_reg.st == S_DEC && !decAdvance |-> fetchRequestN ##1
      (m_reg.st == S_DEC && $stable(fetchedInstructionBus))) // RULE8
      else $error("interlock did not hold decode");
   late_cancel_a: assert property (m_reg.st == S_EXE && priorAbort |=> lateCancelOut && !$past(lateCancelOut)) // RULE10
      else $error("late cancel not one cycle after execute");
   early_ignored_a: assert property (m_reg.st == S_DEC && hs_t'(decodeHandshake) == HS_ABSENT |=>
      !undefTrap) // RULE11
      else $error("decode response acted on before issue");
   sys_ctrl_a: assert property (m_reg.st == S_BUSY && m_reg.kind == K_SYSOUT && hs == HS_GO |->
      instructionAddressBus == m_reg.s0 && dataAddressBus == m_reg.s0) // RULE14
      else $error("system-control data missing on address buses");
   undef_trap_a: assert property (m_reg.st == S_EXE && condPass && hs_t'(decodeHandshake) == HS_ABSENT |=>
      undefTrap ##1 !undefTrap) // RULE19
      else $error("absent handshake did not trap");

   cover_move_in: cover property (takeIssue && issueKind == K_IN1 ##[3:20] destWrite);
   cover_busy: cover property (m_reg.st == S_BUSY ##1 m_reg.st == S_BUSY ##1 commit);
   cover_cancel: cover property (lateCancelOut && xf.busy);
   cover_abandon: cover property (abandon && irqPending);

endmodule : coprocessor_handshake_port

//--- hdl/coproc_port_pkg.sv
// constants and types for the core-side coprocessor handshake port
// assumes one clock, synchronous active-low reset, no software registers
//
// Contract
// [RULE1] fetch low: bus word enters decode
// [RULE2] next fetch low issues; pass raises go-ahead
// [RULE3] execute handshake sampled; LAST commits transfer
// [RULE4] single move out: source on write bus
// [RULE5] single move in: sample memory, write next
// [RULE6] double out: first in exec2, second in memory
// [RULE7] double in: sample exec2 and memory ends
// [RULE8] interlock stalls decode; coprocessor holds instruction
// [RULE9] data op: LAST now, or WAIT then LAST
// [RULE10] late cancel after first execute cycle
// [RULE11] only decode handshake at issue counts
// [RULE12] busy-wait: WAIT decode, then WAIT execute
// [RULE13] go-ahead low in busy-wait means abandon
// [RULE14] system-control move: data on both address buses
// [RULE15] suggested registered read-path select terms
// [RULE16] broadcast controls; AND bit1, OR bit0
// [RULE17] multiplex several coprocessors onto read path
// [RULE18] no coprocessor: tie handshakes to ABSENT
// [RULE19] unaccepted coprocessor instruction takes undefined trap
// [RULE20] handshake codes WAIT 00 GO 01 ABSENT 10 LAST 11
// [RULE21] follower advances only on enabled fetch edge
// [RULE22] no coprocessor state change before go-ahead
// [RULE23] non-claiming coprocessors drive ABSENT
package coproc_port_pkg;

   localparam int DATA_W = 32;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

   // handshake encoding, same on both buses
   typedef enum logic [1:0] {
      HS_WAIT = 2'h0,
      HS_GO = 2'h1,
      HS_ABSENT = 2'h2,
      HS_LAST = 2'h3
   } hs_t; // RULE20

   typedef enum logic [2:0] {
      K_OUT1 = 3'h0,
      K_IN1 = 3'h1,
      K_OUT2 = 3'h2,
      K_IN2 = 3'h3,
      K_DATAOP = 3'h4,
      K_SYSOUT = 3'h5
   } kind_t;

   // core sequencer: gray along idle-decode-execute-busy
   typedef enum logic [1:0] {
      S_IDLE = 2'h0,
      S_DEC = 2'h1,
      S_EXE = 2'h3,
      S_BUSY = 2'h2
   } mst_t;

   // transfer stages after commit
   typedef enum logic [1:0] {
      X_IDLE = 2'h0,
      X_EXE2 = 2'h1,
      X_MEM = 2'h3,
      X_WB = 2'h2
   } xst_t;

   // register data flows from core to coprocessor
   function automatic logic toCoproc(input kind_t k);
      return (k == K_OUT1) || (k == K_OUT2) || (k == K_SYSOUT);
   endfunction : toCoproc

   function automatic logic fromCoproc(input kind_t k);
      return (k == K_IN1) || (k == K_IN2);
   endfunction : fromCoproc

   function automatic logic isDouble(input kind_t k);
      return (k == K_OUT2) || (k == K_IN2);
   endfunction : isDouble

   // kinds that use the write/read data stages
   function automatic logic isTransfer(input kind_t k);
      return (k == K_OUT1) || (k == K_IN1) || isDouble(k);
   endfunction : isTransfer

endpackage : coproc_port_pkg

//--- hdl/xfer_if.sv
// handshake between the core sequencer and the transfer stage unit
// assumes both ends run on the same clock
interface xfer_if;
   import coproc_port_pkg::*;
   logic start;
   kind_t kind;
   logic [DATA_W-1:0] src0;
   logic [DATA_W-1:0] src1;
   logic cancel;
   logic busy;

   modport seq (output start, output kind, output src0, output src1, output cancel, input busy);
   modport unit (input start, input kind, input src0, input src1, input cancel, output busy);
endinterface : xfer_if

//--- hdl/xfer_unit.sv
// data stages of committed register moves: write bus, read sampling, writeback
// assumes start only while idle, one cycle after the committing edge a double is in stage 2, a single in memory
module xfer_unit
   import coproc_port_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   xfer_if.unit xf,
   input wire logic [DATA_W-1:0] readData,
   output logic [DATA_W-1:0] writeData,
   output logic destWrite,
   output logic destDouble,
   output logic [DATA_W-1:0] dest0,
   output logic [DATA_W-1:0] dest1
);

   typedef struct packed {
      xst_t st;
      kind_t kind;
      logic [DATA_W-1:0] s1;
      logic [DATA_W-1:0] wd;
      logic [DATA_W-1:0] d0;
      logic [DATA_W-1:0] d1;
      logic cxl;
   } xstate_t;

   localparam xstate_t X_RESET = '{X_IDLE, K_DATAOP, ZERO_WORD, ZERO_WORD, ZERO_WORD, ZERO_WORD, 1'b0};

   xstate_t x_reg;
   xstate_t x_next;

   // stage sequencing; late cancel only suppresses writeback
   always_comb begin
      x_next = x_reg;
      case (x_reg.st)
         X_IDLE: begin
            if (xf.start) begin
               x_next.kind = xf.kind;
               x_next.s1 = xf.src1;
               x_next.cxl = 1'b0;
               if (toCoproc(xf.kind)) begin
                  x_next.wd = xf.src0; // RULE4
               end
               x_next.st = isDouble(xf.kind) ? X_EXE2 : X_MEM;
            end
         end
         X_EXE2: begin
            if (x_reg.kind == K_IN2) begin
               x_next.d0 = readData; // RULE7
            end
            if (x_reg.kind == K_OUT2) begin
               x_next.wd = x_reg.s1; // RULE6
            end
            x_next.cxl = x_reg.cxl | xf.cancel;
            x_next.st = X_MEM;
         end
         X_MEM: begin
            if (x_reg.kind == K_IN2) begin
               x_next.d1 = readData; // RULE7
            end else if (x_reg.kind == K_IN1) begin
               x_next.d0 = readData; // RULE5
            end
            x_next.cxl = x_reg.cxl | xf.cancel;
            x_next.st = X_WB;
         end
         X_WB: x_next.st = X_IDLE;
         default: x_next = X_RESET;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         x_reg <= X_RESET;
      end else begin
         x_reg <= x_next;
      end
   end

   // writeback in the cycle after the last sample
   assign destWrite = (x_reg.st == X_WB) && !x_reg.cxl && fromCoproc(x_reg.kind); // RULE5 RULE7
   assign destDouble = (x_reg.st == X_WB) && (x_reg.kind == K_IN2);
   assign dest0 = x_reg.d0;
   assign dest1 = x_reg.d1;
   assign writeData = x_reg.wd;
   assign xf.busy = (x_reg.st != X_IDLE);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   single_out_a: assert property (xf.start && xf.kind == K_OUT1 |=> writeData == $past(xf.src0)) // RULE4
      else $error("single move out data wrong");
   double_out_a: assert property (xf.start && xf.kind == K_OUT2 |=>
      writeData == $past(xf.src0) ##1 writeData == $past(xf.src1, 2)) // RULE6
      else $error("double move out order wrong");
   single_in_a: assert property ((xf.start && xf.kind == K_IN1) ##1 !xf.cancel |=>
      destWrite && dest0 == $past(readData)) // RULE5
      else $error("single move in writeback wrong");
   double_in_a: assert property ((xf.start && xf.kind == K_IN2) ##1 !xf.cancel ##1 !xf.cancel |=>
      destWrite && destDouble && dest1 == $past(readData) && dest0 == $past(readData, 2)) // RULE7
      else $error("double move in writeback wrong");
   cover_double_in: cover property (xf.start && xf.kind == K_IN2 ##3 destWrite);

endmodule : xfer_unit

//--- testbench/coproc_follower_model.sv
// coprocessor follower model facing the core-side handshake port
// assumes the port's clock and reset; the bench sets the response knobs
module coproc_follower_model
   import coproc_port_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic fetchRequestN,
   input wire logic goAhead,
   input wire logic lateCancelOut,
   input wire logic privilegeIndicatorN,
   input wire logic [3:0] waitCycles,
   input wire logic useGo,
   input wire logic absent,
   input wire logic privOnly,
   input wire logic [DATA_W-1:0] rd0,
   input wire logic [DATA_W-1:0] rd1,
   output logic [1:0] decodeHandshake,
   output logic [1:0] executeHandshake,
   output logic [DATA_W-1:0] readData,
   output logic [7:0] commits
);
   typedef struct packed {
      logic [3:0] cnt;
      logic [1:0] stage;
      logic pend;
      logic [7:0] commits;
      logic [DATA_W-1:0] pat;
   } model_t;
   model_t stReg, stNext;
   logic refuse;
   logic [1:0] busyCode;
   logic [1:0] ownDec;
   logic [1:0] ownExe;
   // a second coprocessor that never claims anything
   localparam logic [1:0] IDLE_CP = 2'h2;
   // not claiming, or user mode on a privileged-only op
   assign refuse = absent || (privOnly && privilegeIndicatorN);
   assign busyCode = useGo ? HS_GO : HS_WAIT;
   assign ownDec = refuse ? HS_ABSENT : (waitCycles == 4'h0 ? HS_LAST : busyCode);
   assign ownExe = refuse ? HS_ABSENT : (stReg.cnt >= waitCycles ? HS_LAST : busyCode);
   // bit 1 anded, bit 0 ored with the idle neighbour
   assign decodeHandshake = {ownDec[1] & IDLE_CP[1], ownDec[0] | IDLE_CP[0]};
   assign executeHandshake = {ownExe[1] & IDLE_CP[1], ownExe[0] | IDLE_CP[0]};
   // registered stage steers the read return; idle toggles so late samples fail
   assign readData = stReg.stage == 2'h1 ? rd0 : (stReg.stage == 2'h2 ? rd1 : stReg.pat);
   assign commits = stReg.commits;
   // follower state; execute count restarts only on a fetch edge
   always_comb begin
      stNext = stReg;
      stNext.pat = ~stReg.pat;
      stNext.stage = stReg.stage == 2'h1 ? 2'h2 : 2'h0;
      stNext.pend = 1'b0;
      if (!fetchRequestN) begin
         stNext.cnt = 4'h0;
      end else if (stReg.cnt != 4'hF) begin
         stNext.cnt = stReg.cnt + 4'h1;
      end
      if (goAhead && (stReg.cnt == 4'h0 ? decodeHandshake : executeHandshake) == HS_LAST) begin
         stNext.stage = 2'h1;
         stNext.pend = 1'b1;
      end
      if (stReg.pend && !lateCancelOut) begin
         stNext.commits = stReg.commits + 8'h01;
      end
   end
   // register the copy
   always_ff @(posedge clk) begin
      if (!rstn) begin
         stReg <= '0;
      end else begin
         stReg <= stNext;
      end
   end
endmodule : coproc_follower_model

//--- testbench/coprocessor_handshake_port_tb_top.sv
// self-checking bench for the core-side coprocessor port
// assumes the follower model on the pins; inputs change on falling edges
module coprocessor_handshake_port_tb_top
   import coproc_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, issueValid, issueReady, condPass, srcReady, priorAbort, irqPending, privileged;
   logic instrDone, undefTrap, destWrite, destDouble, fetchRequestN, goAhead, lateCancelOut;
   logic privilegeIndicatorN, useGo, absent, privOnly;
   logic [1:0] decodeHandshake, executeHandshake;
   logic [3:0] waitCycles;
   logic [7:0] commits, c;
   kind_t issueKind;
   logic [DATA_W-1:0] issueInstr, srcData0, srcData1, dest0, dest1, fetchedInstructionBus, writeData, readData;
   logic [DATA_W-1:0] instructionAddressBus, dataAddressBus, rd0, rd1;
   int miscompares, cmpCount, cycles;

   coprocessor_handshake_port uut (.clk, .rstn, .issueValid, .issueReady, .issueInstr, .issueKind, .condPass,
      .srcReady, .srcData0, .srcData1, .priorAbort, .irqPending, .privileged, .instrDone, .undefTrap,
      .destWrite, .destDouble, .dest0, .dest1, .fetchRequestN, .fetchedInstructionBus, .decodeHandshake,
      .executeHandshake, .goAhead, .lateCancelOut, .privilegeIndicatorN, .writeData, .readData,
      .instructionAddressBus, .dataAddressBus);
   coproc_follower_model cop (.clk, .rstn, .fetchRequestN, .goAhead, .lateCancelOut, .privilegeIndicatorN,
      .waitCycles, .useGo, .absent, .privOnly, .rd0, .rd1, .decodeHandshake, .executeHandshake, .readData,
      .commits);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step

   // hold the offer until ready, then land in the decode cycle
   task automatic issue(input kind_t k, input logic [DATA_W-1:0] s0, input logic [DATA_W-1:0] s1);
      issueKind = k;
      issueInstr = s0 ^ s1;
      srcData0 = s0;
      srcData1 = s1;
      issueValid = 1'b1;
      while (issueReady !== 1'b1) step(1);
      step(1);
      issueValid = 1'b0;
      chk(fetchedInstructionBus, s0 ^ s1);
      c = commits;
   endtask : issue

   task automatic t_move_in();
      rd0 = 32'hA5A5_0001;
      issue(K_IN1, 32'h0000_1111, 32'h0);
      chk(fetchRequestN, 1'b0);
      step(1);
      chk(goAhead, 1'b1);
      step(1);
      chk(instrDone, 1'b1);
      step(1);
      chk({destWrite, dest0}, {1'b1, rd0});
      chk(commits, c + 8'h01);
      $display("move in done");
   endtask : t_move_in

   // interlocked move out with two busy cycles
   task automatic t_move_out();
      srcReady = 1'b0;
      waitCycles = 4'h2;
      issue(K_OUT1, 32'h1234_5678, 32'h0);
      chk(fetchRequestN, 1'b1);
      step(2);
      chk(fetchRequestN, 1'b1);
      srcReady = 1'b1;
      step(2);
      chk({goAhead, instrDone}, 2'h2);
      step(1);
      chk({goAhead, instrDone}, 2'h2);
      step(1);
      chk({instrDone, writeData}, {1'b1, 32'h1234_5678});
      waitCycles = 4'h0;
      $display("move out done");
   endtask : t_move_out

   task automatic t_double();
      issue(K_OUT2, 32'hCAFE_0001, 32'hBEEF_0002);
      step(2);
      chk(writeData, 32'hCAFE_0001);
      step(1);
      chk(writeData, 32'hBEEF_0002);
      rd0 = 32'h0F0F_0003;
      rd1 = 32'hF0F0_0004;
      issue(K_IN2, 32'h0, 32'h0);
      step(4);
      chk({destWrite, destDouble, dest0, dest1}, {2'h3, rd0, rd1});
      $display("double done");
   endtask : t_double

   task automatic t_cancel();
      // abort must stand at the edge that ends the first execute cycle
      issue(K_DATAOP, 32'h0000_00CD, 32'h0);
      priorAbort = 1'b1;
      step(2);
      priorAbort = 1'b0;
      chk(lateCancelOut, 1'b1);
      step(1);
      chk(commits, c);
      issue(K_IN1, 32'h0000_2222, 32'h0);
      priorAbort = 1'b1;
      step(2);
      priorAbort = 1'b0;
      step(1);
      chk(destWrite, 1'b0);
      $display("cancel done");
   endtask : t_cancel

   task automatic t_irq();
      waitCycles = 4'h5;
      issue(K_DATAOP, 32'h0000_0101, 32'h0);
      step(3);
      irqPending = 1'b1;
      #1;
      chk(goAhead, 1'b0);
      step(1);
      irqPending = 1'b0;
      chk({instrDone, undefTrap}, 2'h2);
      chk(commits, c);
      waitCycles = 4'h0;
      $display("irq done");
   endtask : t_irq

   task automatic t_trap();
      absent = 1'b1;
      condPass = 1'b0;
      issue(K_DATAOP, 32'h0000_0303, 32'h0);
      step(1);
      chk(goAhead, 1'b0);
      step(1);
      chk({instrDone, undefTrap}, 2'h2);
      absent = 1'b0;
      condPass = 1'b1;
      privOnly = 1'b1;
      privileged = 1'b0;
      issue(K_DATAOP, 32'h0000_0404, 32'h0);
      step(2);
      chk(undefTrap, 1'b1);
      privileged = 1'b1;
      step(1);
      chk(privilegeIndicatorN, 1'b0);
      issue(K_DATAOP, 32'h0000_0505, 32'h0);
      step(2);
      chk({instrDone, undefTrap}, 2'h2);
      privOnly = 1'b0;
      $display("trap done");
   endtask : t_trap

   task automatic t_cp15();
      useGo = 1'b1;
      waitCycles = 4'h2;
      issue(K_SYSOUT, 32'h7777_0015, 32'h0);
      step(1);
      chk({instructionAddressBus, dataAddressBus}, {2{32'h7777_0015}});
      step(1);
      chk({instructionAddressBus, dataAddressBus}, {2{32'h7777_0015}});
      step(2);
      chk({instrDone, undefTrap}, 2'h2);
      useGo = 1'b0;
      waitCycles = 4'h0;
      $display("cp15 done");
   endtask : t_cp15

   task automatic endSim();
      $display("compares %0d mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : endSim

   // hang guard, far above the few dozen cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         endSim();
      end
   end

   initial begin
      {rstn, issueValid, priorAbort, irqPending, useGo, absent, privOnly} = '0;
      {condPass, srcReady, privileged} = 3'h7;
      {issueInstr, srcData0, srcData1, rd0, rd1} = '0;
      issueKind = K_DATAOP;
      waitCycles = 4'h0;
      step(4);
      rstn = 1'b1;
      t_move_in();
      t_move_out();
      t_double();
      t_cancel();
      t_irq();
      t_trap();
      t_cp15();
      step(3);
      endSim();
   end
endmodule : coprocessor_handshake_port_tb_top
